// ---- sram_port_pkg.sv ----
// Shared constants and types for the flow-through burst memory port.
// Assumes a single clock domain; all users import the whole package.
`default_nettype none
package sram_port_pkg;
	localparam int SRAM_WORDS  = 262144;
	localparam int SRAM_ADDR_W = 18;
	localparam int SRAM_DATA_W = 18;
	localparam int SRAM_LANES  = 2;
	localparam int BURST_W     = 2;

	typedef logic [BURST_W-1:0] burst_t;

	// Gray along idle -> read -> write
	typedef enum logic [1:0] {
		ST_IDLE  = 2'h0,
		ST_READ  = 2'h1,
		ST_WRITE = 2'h3
	} port_state_e;

	// Synchronous control pins, all sampled on the rising edge
	typedef struct packed {
		logic                  processor_addr_strobe_n;
		logic                  controller_addr_strobe_n;
		logic                  burst_advance_n;
		logic                  master_select_n;
		logic                  secondary_select_hi;
		logic                  secondary_select_lo_n;
		logic                  global_write_n;
		logic                  byte_write_gate_n;
		logic [SRAM_LANES-1:0] byte_lane_write_n_bus;
	} sram_ctl_s;
endpackage : sram_port_pkg
`default_nettype wire

// ---- sram_lane_mem.sv ----
// Word-wide storage with per-lane write enables and a registered read.
// Assumes write and read addresses are presented before the same edge.
`default_nettype none
module sram_lane_mem #(
	parameter int ADDR_W = 18,
	parameter int DATA_W = 18,
	parameter int LANES  = 2
) (
	input  wire logic              sys_clk,
	input  wire logic [LANES-1:0]  laneWr,
	input  wire logic [ADDR_W-1:0] wrAddr,
	input  wire logic [DATA_W-1:0] wrData,
	input  wire logic [ADDR_W-1:0] rdAddr,
	output var  logic [DATA_W-1:0] rdData
);
	localparam int LANE_W = DATA_W / LANES;

	if (DATA_W % LANES != 0) begin : gBadLanes
		$error("sram_lane_mem: data width must split evenly into lanes");
	end

	logic [DATA_W-1:0] mem [0:(1<<ADDR_W)-1];

	// Lane writes land on the edge that samples them; one process owns the array
	always_ff @(posedge sys_clk) begin
		for (int l = 0; l < LANES; l++) begin
			if (laneWr[l]) begin
				mem[wrAddr][l*LANE_W +: LANE_W] <= wrData[l*LANE_W +: LANE_W];
			end
		end
	end

	// Read of the newly registered address: one flop, no extra stage
	always_ff @(posedge sys_clk) begin
		rdData <= mem[rdAddr];
	end
endmodule : sram_lane_mem
`default_nettype wire

// ---- flow_through_burst_sram_port.sv ----
// Synchronous access logic of an 18-bit flow-through burst memory.
// Assumes all pins except output enable and burst order are synchronous to sys_clk.
`default_nettype none
module flow_through_burst_sram_port
	import sram_port_pkg::*;
#(
	parameter int ADDR_W = sram_port_pkg::SRAM_ADDR_W,
	parameter int DATA_W = sram_port_pkg::SRAM_DATA_W,
	parameter int LANES  = sram_port_pkg::SRAM_LANES
) (
	input  wire logic                     sys_clk,
	input  wire logic                     rst,
	input  wire sram_port_pkg::sram_ctl_s ctl,
	input  wire logic [ADDR_W-1:0]        extAddr,
	input  wire logic [DATA_W-1:0]        dqIn,
	output var  logic [DATA_W-1:0]        dqOut,
	output var  logic                     dqOe_n,
	input  wire logic                     outEnable_n,
	input  wire logic                     linear_order_select_n
);
	import sram_port_pkg::*;

	if (LANES != SRAM_LANES || ADDR_W <= BURST_W || DATA_W % LANES != 0) begin : gBadParam
		$error("flow_through_burst_sram_port: unsupported width or lane count");
	end

	port_state_e               state_r;
	port_state_e               state_nxt;
	logic [ADDR_W-1:BURST_W]   hiAddr_r;
	burst_t                    base_r;
	burst_t                    count_r;
	burst_t                    countInc;
	logic                      selPart;
	logic                      procTake;
	logic                      ctrlTake;
	logic                      procStart;
	logic                      ctrlStart;
	logic                      load;
	logic                      deselect;
	logic                      burstOn;
	logic                      advance;
	logic                      linear;
	logic [LANES-1:0]          laneReq;
	logic [LANES-1:0]          laneWr;
	logic [ADDR_W-1:0]         curAddr;
	logic [ADDR_W-1:0]         effAddr;
	logic [ADDR_W-1:0]         rdAddr;
	logic [DATA_W-1:0]         rdData;

	// Low address bits of the burst, wrapping inside four words
	function automatic burst_t burstLow(input burst_t base, input burst_t cnt, input logic lin);
		burstLow = lin ? burst_t'(base + cnt) : (base ^ cnt);
	endfunction : burstLow

	// Floating order pin is pulled high outside, so high means interleaved
	assign linear   = ~linear_order_select_n;
	assign selPart  = ctl.secondary_select_hi & ~ctl.secondary_select_lo_n;
	assign procTake = ~ctl.processor_addr_strobe_n & ~ctl.master_select_n;
	// A blocked processor strobe counts as high for a controller start
	assign ctrlTake = ~ctl.controller_addr_strobe_n & ~procTake;
	assign procStart = procTake & selPart;
	assign ctrlStart = ctrlTake & selPart;
	assign load      = procStart | ctrlStart;
	assign deselect  = (procTake | ctrlTake) & ~selPart;
	assign burstOn   = (state_r != ST_IDLE) & ~procTake & ~ctrlTake;
	assign advance   = burstOn & ctl.processor_addr_strobe_n & ctl.controller_addr_strobe_n
	                   & ~ctl.burst_advance_n;
	assign countInc  = burst_t'(count_r + burst_t'(1));

	// Global write overrides lanes; otherwise lanes only under the gate
	always_comb begin
		if (!ctl.global_write_n) begin
			laneReq = '1;
		end else if (!ctl.byte_write_gate_n) begin
			laneReq = ~ctl.byte_lane_write_n_bus;
		end else begin
			laneReq = '0;
		end
	end

	// Processor start edge never writes; controller start may
	assign laneWr = (ctrlStart | burstOn) ? laneReq : '0;

	assign curAddr = {hiAddr_r, burstLow(base_r, count_r, linear)};
	assign effAddr = load ? extAddr : curAddr;
	// Next read address: advance is ignored on a load edge
	assign rdAddr  = load ? extAddr
	               : advance ? {hiAddr_r, burstLow(base_r, countInc, linear)} : curAddr;

	always_ff @(posedge sys_clk) begin
		if (rst) begin
			hiAddr_r <= '0;
			base_r   <= '0;
		end else if (load) begin
			hiAddr_r <= extAddr[ADDR_W-1:BURST_W];
			base_r   <= extAddr[BURST_W-1:0];
		end
	end

	always_ff @(posedge sys_clk) begin
		if (rst) begin
			count_r <= '0;
		end else if (load) begin
			count_r <= '0;
		end else if (advance) begin
			count_r <= countInc;
		end
	end

	always_comb begin
		state_nxt = state_r;
		if (deselect) begin
			state_nxt = ST_IDLE;
		end else if (load || burstOn) begin
			state_nxt = (|laneWr) ? ST_WRITE : ST_READ;
		end
	end

	always_ff @(posedge sys_clk) begin
		if (rst) begin
			state_r <= ST_IDLE;
		end else begin
			state_r <= state_nxt;
		end
	end

	// Output enable is asynchronous, so in ST_READ the pin follows it without a flop
	always_comb begin
		unique case (state_r)
			ST_IDLE:  dqOe_n = 1'b1;
			ST_READ:  dqOe_n = outEnable_n;
			ST_WRITE: dqOe_n = 1'b1;
			default:  dqOe_n = 1'b1;
		endcase
	end

	sram_lane_mem #(
		.ADDR_W (ADDR_W),
		.DATA_W (DATA_W),
		.LANES  (LANES)
	) uMem (
		.sys_clk (sys_clk),
		.laneWr  (laneWr),
		.wrAddr  (effAddr),
		.wrData  (dqIn),
		.rdAddr  (rdAddr),
		.rdData  (rdData)
	);

	assign dqOut = rdData;

	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (rst);

	AST_PROC_LOAD: assert property (procStart |=> curAddr == $past(extAddr) && state_r == ST_READ)
		else $error("processor start did not load the address");
	AST_ADV_IGNORED: assert property (procStart && !ctl.burst_advance_n |=> count_r == 2'h0)
		else $error("advance acted on a processor strobe edge");
	AST_ADVANCE: assert property (advance |=> count_r == burst_t'($past(count_r) + 2'h1))
		else $error("burst count did not step");
	AST_HOLD: assert property (burstOn && ctl.burst_advance_n |=> $stable(curAddr))
		else $error("burst address moved without advance");
	AST_ORDER: assert property (state_r != ST_IDLE && !linear
		|-> curAddr[BURST_W-1:0] == (base_r ^ count_r))
		else $error("interleaved order broken");
	AST_GLOBAL: assert property (burstOn && !ctl.global_write_n |-> &laneWr)
		else $error("global write missed a lane");
	AST_GATE: assert property (ctl.global_write_n && ctl.byte_write_gate_n |-> laneWr == '0)
		else $error("lane written without gate");
	AST_PROC_NOWRITE: assert property (procStart |-> laneWr == '0)
		else $error("write on processor strobe edge");
	AST_WRITE_OFF: assert property (|laneWr && !deselect |=> dqOe_n)
		else $error("drivers on after a write edge");
	AST_CTRL_WRITE: assert property (ctrlStart && !ctl.global_write_n |-> &laneWr ##1 state_r == ST_WRITE)
		else $error("controller start ignored write");
	AST_BLOCKED: assert property (state_r == ST_IDLE && ctl.master_select_n
		&& ctl.controller_addr_strobe_n |=> state_r == ST_IDLE)
		else $error("blocked processor strobe selected the chip");
	AST_IDLE_OFF: assert property (state_r == ST_IDLE |-> dqOe_n)
		else $error("drivers on while deselected");

	COV_READ_BURST: cover property (procStart ##1 advance [*3]);
	COV_CTRL_WRITE: cover property (ctrlStart && |laneWr ##1 advance && |laneWr);
	COV_LINEAR_WRAP: cover property (linear && advance && count_r == 2'h3);
	COV_DESELECT: cover property (state_r == ST_READ ##1 state_r == ST_IDLE);
endmodule : flow_through_burst_sram_port
`default_nettype wire

// ---- bus_master_model.sv ----
// Bus master model: drives memory control, address and write data pins.
// Assumes the bench calls step once per cycle, just after the rising edge.
`default_nettype none
module bus_master_model
	import sram_port_pkg::*;
(
	output var sram_port_pkg::sram_ctl_s ctl,
	output var logic [17:0]              extAddr,
	output var logic [17:0]              dqIn,
	output var logic                     outEnable_n
);
	timeunit 1ns;
	timeprecision 1ns;
	initial begin
		ctl = '1;
		extAddr = '0;
		dqIn = '0;
		outEnable_n = 1'b1;
	end
	// Strobes rare so bursts run long enough to wrap
	task automatic step(input logic [31:0] r);
		logic wr;
		wr = ~|r[19:18] | (~r[20] & ~&r[22:21]);
		ctl = sram_ctl_s'({|r[3:0], |r[7:4], r[8], &r[11:9], |r[14:12], &r[17:15], |r[19:18], r[20], r[22:21]});
		outEnable_n = wr | r[23];
		extAddr = {r[31], 13'h0, r[27:24]};
		dqIn = r[17:0] ^ r[31:14];
	endtask : step
endmodule : bus_master_model
`default_nettype wire

// ---- test_flow_through_burst_sram_port.sv ----
// Bench: random bus traffic compared against a word-level memory model.
// Assumes the design's notes on latency, deselect and write state.
`default_nettype none
module test_flow_through_burst_sram_port
	import sram_port_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ns;
	logic        sysClk = 1'b0;
	logic        rst = 1'b1;
	logic        orderSel_n = 1'b1;
	sram_ctl_s   ctl;
	logic [17:0] extAddr, dqIn, dqOut, expD, base;
	logic        outEnable_n, dqOe_n;
	logic [31:0] seed = 32'd21773;
	logic [1:0]  cnt = '0;
	logic [17:0] mem [int];
	int          st = 0;
	int          bad_count = 0;
	int          total_checks = 0;
	always #5 sysClk = ~sysClk;
	bus_master_model bm (.ctl(ctl), .extAddr(extAddr), .dqIn(dqIn), .outEnable_n(outEnable_n));
	flow_through_burst_sram_port uut (.sys_clk(sysClk), .rst(rst), .ctl(ctl), .extAddr(extAddr),
		.dqIn(dqIn), .dqOut(dqOut), .dqOe_n(dqOe_n), .outEnable_n(outEnable_n),
		.linear_order_select_n(orderSel_n));
	function automatic logic [31:0] lfsr(input logic [31:0] s);
		repeat (32) s = {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
		return s;
	endfunction : lfsr
	function automatic logic [17:0] burstAddr(input logic [17:0] b, input logic [1:0] c);
		return {b[17:2], orderSel_n ? b[1:0] ^ c : b[1:0] + c};
	endfunction : burstAddr
	task automatic check(input logic [17:0] got, input logic [17:0] exp);
		total_checks++;
		if (got !== exp) begin
			bad_count++;
			$display("Error %0t: saw %h expected %h", $time, got, exp);
		end
	endtask : check
	task automatic tally_and_finish;
		$display("checks %0d mismatches %0d", total_checks, bad_count);
		if (bad_count == 0 && total_checks > 0) begin
			$display("== PASSED ==");
		end else begin
			$display("== FAILED ==");
		end
		$finish;
	endtask : tally_and_finish
	// Reference model, updated on each edge from the sampled pins
	always @(posedge sysClk) begin : model
		sram_ctl_s   k;
		logic        ps, cs, sel, go;
		logic [17:0] msk, a;
		k = ctl;
		go = 1'b0;
		ps = !k.processor_addr_strobe_n & !k.master_select_n;
		cs = !k.controller_addr_strobe_n & !ps;
		sel = k.secondary_select_hi & !k.secondary_select_lo_n;
		msk = !k.global_write_n ? '1 : k.byte_write_gate_n ? '0 :
			{{9{!k.byte_lane_write_n_bus[1]}}, {9{!k.byte_lane_write_n_bus[0]}}};
		if (rst) begin
			st = 0;
		end else if ((ps | cs) & !sel) begin
			st = 0;
		end else if (ps | cs) begin
			base = extAddr;
			cnt = '0;
			st = (cs & msk != 0) ? 2 : 1;
		end else if (st != 0) begin
			// Step only after the write: a burst write lands on the current word
			go = !k.burst_advance_n & k.processor_addr_strobe_n & k.controller_addr_strobe_n;
			st = (msk != 0) ? 2 : 1;
		end
		if (st == 2) begin
			a = burstAddr(base, cnt);
			mem[a] = ((mem.exists(a) ? mem[a] : 'x) & ~msk) | (dqIn & msk);
		end
		if (go) begin
			cnt++;
		end
		a = burstAddr(base, cnt);
		expD = (st != 0 && mem.exists(a)) ? mem[a] : 'x;
	end
	always @(negedge sysClk) begin
		if (!rst) begin
			check(dqOe_n, (st == 1) ? outEnable_n : 1'b1);
			if (st == 1 && ^expD !== 1'bx) begin
				check(dqOut, expD);
			end
		end
	end
	initial begin
		#200us;
		bad_count++;
		tally_and_finish();
	end
	// Second pass resets mid-run; order pin only changes under reset
	initial begin
		for (int t = 0; t < 2; t++) begin
			rst = 1'b1;
			orderSel_n = t[0];
			repeat (t == 0 ? 20 : 3) @(posedge sysClk);
			#1 rst = 1'b0;
			repeat (3000) begin
				@(posedge sysClk);
				#1 seed = lfsr(seed);
				bm.step(seed);
			end
			// Idle pins, or the next reset would see a stale start and write
			@(posedge sysClk);
			#1 bm.step(32'hffffffff);
			$display("test %0d done", t);
		end
		tally_and_finish();
	end
endmodule : test_flow_through_burst_sram_port
`default_nettype wire
